// File: rtl/tc_pkg.sv
// constants shared by the capture/compare and output-level block
// assumes a single reference clock and a count-clock enable pulse
package tc_pkg;
   localparam int         CNT_W          = 16;
   // operating mode codes
   localparam logic [1:0] MODE_STOP      = 2'h0;
   localparam logic [1:0] MODE_FREE      = 2'h1;
   localparam logic [1:0] MODE_CLR_EDGE  = 2'h2;
   localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
   // {output_level_set, output_level_reset}
   localparam logic [1:0] LVL_KEEP       = 2'h0;
   localparam logic [1:0] LVL_LOW        = 2'h1;
   localparam logic [1:0] LVL_HIGH       = 2'h2;
   // valid-edge selection
   localparam logic [1:0] EDGE_FALL      = 2'h0;
   localparam logic [1:0] EDGE_RISE      = 2'h1;
   localparam logic [1:0] EDGE_NONE      = 2'h2;
   localparam logic [1:0] EDGE_BOTH      = 2'h3;
   // reset values
   localparam logic       OUT_RST        = 1'b0;
   localparam logic       LEVEL_RST      = 1'b0;
endpackage

// File: rtl/tc_edge_if.sv
// edge-filter hookup between the top and its input filters
// assumes both ends share i_ref_clk
interface tc_edge_if;
   logic       sample_en;
   logic       pin;
   logic [1:0] edge_sel;
   logic       valid_edge;
   logic       reverse_edge;
   modport filt (input sample_en, pin, edge_sel, output valid_edge, reverse_edge);
   modport user (output sample_en, pin, edge_sel, input valid_edge, reverse_edge);
endinterface

// File: rtl/tc_edge_filter.sv
// noise filter and edge classifier for one capture input
// assumes pin is already synchronised and sample_en is the count tick
module tc_edge_filter (
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   tc_edge_if.filt   eif
);
   import tc_pkg::*;

   logic prev_sample;
   logic level;
   logic valid_q;
   logic rev_q;
   logic next_prev_sample;
   logic next_level;
   logic next_valid_q;
   logic next_rev_q;
   logic rise;
   logic fall;

   function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         EDGE_FALL: edge_hit = f;
         EDGE_RISE: edge_hit = r;
         EDGE_BOTH: edge_hit = r | f;
         default:   edge_hit = 1'b0;
      endcase
   endfunction

   always_comb begin
      next_prev_sample = prev_sample;
      next_level       = level;
      rise             = 1'b0;
      fall             = 1'b0;
      if (eif.sample_en) begin
         next_prev_sample = eif.pin;
         // two equal samples in a row needed before the level moves
         if (eif.pin == prev_sample && eif.pin != level) begin // R24
            next_level = eif.pin;
            rise       = eif.pin;
            fall       = ~eif.pin;
         end
      end
      next_valid_q = edge_hit(eif.edge_sel, rise, fall);
      next_rev_q   = (eif.edge_sel == EDGE_RISE || eif.edge_sel == EDGE_FALL) ?
                     edge_hit(eif.edge_sel, fall, rise) : 1'b0;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         prev_sample <= LEVEL_RST;
         level       <= LEVEL_RST;
         valid_q     <= 1'b0;
         rev_q       <= 1'b0;
      end else begin
         prev_sample <= next_prev_sample;
         level       <= next_level;
         valid_q     <= next_valid_q;
         rev_q       <= next_rev_q;
      end
   end

   assign eif.valid_edge   = valid_q;
   assign eif.reverse_edge = rev_q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   property p_single_sample_rejected;
      (eif.sample_en && eif.pin != prev_sample) |=> (!eif.valid_edge && !eif.reverse_edge);
   endproperty
   a_single_sample_rejected: assert property (p_single_sample_rejected) // R24
      else $error("edge reported after a single sample");
endmodule

// File: rtl/tc_capture_top.sv
// capture/compare registers, counter and timer output level control
// assumes i_count_en is a one-cycle count tick on i_ref_clk and pins are asynchronous
// How it works
// R1: register A loads the counter on its selected trigger, input B or reverse edge of A.
// R2: register B loads the counter on a valid edge of input A only.
// R3: a reverse-edge capture into register A raises no interrupt A.
// R4: software leaves compare values alone while running, except the register B duty change.
// R5: software lowers B after a B match, raises it after an A match.
// R6: software masks, disables B inversion, writes, waits a tick, re-enables, clears, unmasks.
// R7: level code 00 keeps, 01 drives low, 10 drives high; 11 never written.
// R8: software touches level bits only while the counter is stopped.
// R9: after a forced high, code 00 keeps the output high.
// R10: modes 01, 10, 11 start counting; output starts from the preset level.
// R11: while running with output enabled, each interrupt A inverts the output.
// R12: edge-clear mode with input B detection: software keeps output control at zero.
// R13: pattern output needs zero <= B value < A value <= all ones.
// R14: one-shot output never uses equal values in A and B.
// R15: pulse width measurement: software keeps output control at zero.
// R16: first match after start may come up to one count tick late.
// R17: match-clear mode: software programs both registers nonzero.
// R18: capture proceeds during a read; interrupts only for valid edges.
// R19: software reads a capture register only after its capture interrupt.
// R20: register contents after the counter stops are not to be relied on.
// R21: mode 00 stopped, 01 free running, 10 clear and start on input A edge.
// R22: edge-clear mode: valid A edge captures into B and clears; reverse into A.
// R23: capture on the count tick, interrupt raised on the following tick.
// R24: an edge counts only after two equal consecutive samples.
module tc_capture_top #(
   parameter int WIDTH = tc_pkg::CNT_W
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_count_en,
   input  wire logic [1:0]       i_mode,
   input  wire logic             i_capture_in_a,
   input  wire logic             i_capture_in_b,
   input  wire logic [1:0]       i_edge_sel_a,
   input  wire logic [1:0]       i_edge_sel_b,
   input  wire logic             i_reg_a_capture,
   input  wire logic             i_reg_a_rev_trig,
   input  wire logic             i_reg_b_capture,
   input  wire logic             i_wr_reg_a,
   input  wire logic             i_wr_reg_b,
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic             i_output_level_set,
   input  wire logic             i_output_level_reset,
   input  wire logic             i_output_enable,
   input  wire logic             i_match_b_invert_enable,
   input  wire logic             i_overflow_clear,
   output logic [WIDTH-1:0]      o_timer_counter_value,
   output logic [WIDTH-1:0]      o_capture_compare_reg_a,
   output logic [WIDTH-1:0]      o_capture_compare_reg_b,
   output logic                  o_match_capture_irq_a,
   output logic                  o_match_capture_irq_b,
   output logic                  o_timer_output_pin,
   output logic                  o_overflow_flag
);
   import tc_pkg::*;

   if (WIDTH < 2 || WIDTH > 32) begin : g_width_check
      $error("tc_capture_top: WIDTH must be 2 to 32");
   end

   tc_edge_if eif_a ();
   tc_edge_if eif_b ();

   logic [1:0]       sync_a;
   logic [1:0]       sync_b;
   logic [WIDTH-1:0] counter;
   logic [WIDTH-1:0] reg_a;
   logic [WIDTH-1:0] reg_b;
   logic             pend_a;
   logic             pend_b;
   logic             irq_a;
   logic             irq_b;
   logic             timer_out;
   logic             overflow;

   logic [WIDTH-1:0] next_counter;
   logic [WIDTH-1:0] next_reg_a;
   logic [WIDTH-1:0] next_reg_b;
   logic             next_pend_a;
   logic             next_pend_b;
   logic             next_irq_a;
   logic             next_irq_b;
   logic             next_timer_out;
   logic             next_overflow;

   logic             running;
   logic             tick;
   logic             match_a;
   logic             match_b;
   logic             cap_a;
   logic             cap_b;
   logic             cap_irq_a;
   logic             toggle_b;
   logic [1:0]       level_code;

   // pin synchronisers
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         sync_a <= 2'h0;
         sync_b <= 2'h0;
      end else begin
         sync_a <= {sync_a[0], i_capture_in_a};
         sync_b <= {sync_b[0], i_capture_in_b};
      end
   end

   assign running = (i_mode != MODE_STOP); // R21
   assign tick    = i_count_en & running;

   // inputs are ignored while stopped; filter level is kept across stops
   assign eif_a.sample_en = tick;
   assign eif_a.pin       = sync_a[1];
   assign eif_a.edge_sel  = i_edge_sel_a;
   assign eif_b.sample_en = tick;
   assign eif_b.pin       = sync_b[1];
   assign eif_b.edge_sel  = i_edge_sel_b;

   tc_edge_filter u_filt_a (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .eif       (eif_a)
   );

   tc_edge_filter u_filt_b (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .eif       (eif_b)
   );

   assign level_code = {i_output_level_set, i_output_level_reset};

   always_comb begin
      // compares only on the tick, so start phase adds up to one tick
      match_a   = tick & ~i_reg_a_capture & (counter == reg_a); // R16
      match_b   = tick & ~i_reg_b_capture & (counter == reg_b);
      cap_a     = running & i_reg_a_capture &
                  (i_reg_a_rev_trig ? eif_a.reverse_edge : eif_b.valid_edge); // R1
      // valid B edges still interrupt in reverse-trigger setup; reverse A edges never do
      cap_irq_a = running & i_reg_a_capture & eif_b.valid_edge; // R3
      cap_b     = running & i_reg_b_capture & eif_a.valid_edge; // R2
      toggle_b  = match_b & i_match_b_invert_enable;

      // capture value is latched now, interrupt waits for the next tick
      next_pend_a = (pend_a & ~tick) | cap_irq_a; // R23
      next_pend_b = (pend_b & ~tick) | cap_b;
      next_irq_a  = (pend_a & tick) | match_a; // R23
      next_irq_b  = (pend_b & tick) | match_b;

      // capture wins over a software write in the same cycle; read never blocks it
      next_reg_a = reg_a;
      if (cap_a) begin
         next_reg_a = counter; // R18
      end else if (i_wr_reg_a) begin
         next_reg_a = i_wr_data;
      end
      next_reg_b = reg_b;
      if (cap_b) begin
         next_reg_b = counter; // R22
      end else if (i_wr_reg_b) begin
         next_reg_b = i_wr_data;
      end

      next_counter  = counter;
      next_overflow = overflow & ~i_overflow_clear;
      if (!running) begin
         next_counter = '0;
      end else if (i_mode == MODE_CLR_EDGE && eif_a.valid_edge) begin
         next_counter = '0; // R22
      end else if (tick) begin // R10
         if (counter == '1) begin
            next_overflow = 1'b1;
         end
         if (i_mode == MODE_CLR_MATCH && counter == reg_a) begin
            next_counter = '0;
         end else begin
            next_counter = WIDTH'(counter + 1'b1);
         end
      end

      next_timer_out = timer_out;
      if (!running) begin
         unique case (level_code)
            LVL_HIGH: next_timer_out = 1'b1; // R7
            LVL_LOW:  next_timer_out = 1'b0; // R7
            default:  next_timer_out = timer_out; // R9
         endcase
      end else if (i_output_enable) begin
         // starts from the preset level held while stopped
         next_timer_out = timer_out ^ next_irq_a ^ toggle_b; // R11
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         counter   <= '0;
         reg_a     <= '0;
         reg_b     <= '0;
         pend_a    <= 1'b0;
         pend_b    <= 1'b0;
         irq_a     <= 1'b0;
         irq_b     <= 1'b0;
         timer_out <= OUT_RST;
         overflow  <= 1'b0;
      end else begin
         counter   <= next_counter;
         reg_a     <= next_reg_a;
         reg_b     <= next_reg_b;
         pend_a    <= next_pend_a;
         pend_b    <= next_pend_b;
         irq_a     <= next_irq_a;
         irq_b     <= next_irq_b;
         timer_out <= next_timer_out;
         overflow  <= next_overflow;
      end
   end

   // capture/compare registers are not cleared on stop; their value then is not meaningful
   assign o_timer_counter_value   = counter;
   assign o_capture_compare_reg_a = reg_a; // R20
   assign o_capture_compare_reg_b = reg_b;
   assign o_match_capture_irq_a   = irq_a;
   assign o_match_capture_irq_b   = irq_b;
   assign o_timer_output_pin      = timer_out;
   assign o_overflow_flag         = overflow;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   property p_cap_a_loads;
      (running && i_reg_a_capture && i_reg_a_rev_trig && eif_a.reverse_edge) |=>
         (o_capture_compare_reg_a == $past(counter));
   endproperty
   a_cap_a_loads: assert property (p_cap_a_loads) // R1
      else $error("register A missed a reverse-edge capture");

   property p_cap_b_loads;
      (running && i_reg_b_capture && eif_a.valid_edge) |=> (o_capture_compare_reg_b == $past(counter));
   endproperty
   a_cap_b_loads: assert property (p_cap_b_loads) // R2
      else $error("register B missed a capture");

   property p_rev_no_irq;
      (i_reg_a_rev_trig && eif_a.reverse_edge && !eif_b.valid_edge && !pend_a) |=> !pend_a;
   endproperty
   a_rev_no_irq: assert property (p_rev_no_irq) // R3
      else $error("reverse-edge capture raised an interrupt");

   property p_lvl_high;
      (!running && level_code == LVL_HIGH) |=> o_timer_output_pin;
   endproperty
   a_lvl_high: assert property (p_lvl_high) // R7
      else $error("level code high did not drive output high");

   property p_lvl_low;
      (!running && level_code == LVL_LOW) |=> !o_timer_output_pin;
   endproperty
   a_lvl_low: assert property (p_lvl_low) // R7
      else $error("level code low did not drive output low");

   property p_keep_high;
      (!running && level_code == LVL_KEEP && o_timer_output_pin) |=> o_timer_output_pin;
   endproperty
   a_keep_high: assert property (p_keep_high) // R9
      else $error("output dropped on level code keep");

   property p_irq_next_tick;
      (pend_a && tick) |=> o_match_capture_irq_a;
   endproperty
   a_irq_next_tick: assert property (p_irq_next_tick) // R23
      else $error("capture interrupt not raised on the next tick");

   property p_stop_clear;
      (i_mode == MODE_STOP) [*2] |-> (o_timer_counter_value == '0);
   endproperty
   a_stop_clear: assert property (p_stop_clear) // R21
      else $error("counter not held at zero while stopped");

   property p_free_count;
      (tick && i_mode == MODE_FREE && !eif_a.valid_edge) |=>
         (o_timer_counter_value == WIDTH'($past(counter) + 1'b1));
   endproperty
   a_free_count: assert property (p_free_count) // R10
      else $error("counter did not advance on a tick");

   property p_clr_edge;
      (i_mode == MODE_CLR_EDGE && eif_a.valid_edge) |=> (o_timer_counter_value == '0);
   endproperty
   a_clr_edge: assert property (p_clr_edge) // R22
      else $error("counter not cleared on valid edge");

   property p_toggle;
      (running && i_output_enable && next_irq_a && !toggle_b) |=>
         (o_timer_output_pin != $past(o_timer_output_pin));
   endproperty
   a_toggle: assert property (p_toggle) // R11
      else $error("output did not invert on interrupt A");

   c_cap_a:    cover property (running && cap_a ##1 1'b1);
   c_cap_b:    cover property (cap_b ##[1:20] o_match_capture_irq_b);
   c_toggle:   cover property (running && i_output_enable && o_match_capture_irq_a);
   c_overflow: cover property ($rose(o_overflow_flag));
endmodule

// File: bench/tc_pulse_src.sv
// model of the external pulse sources on the two capture pins
// assumes the bench sets the wanted levels; pins move off the clock phase
module tc_pulse_src #(
   parameter int SKEW_NS = 7
) (
   input  wire logic i_lvl_a,
   input  wire logic i_lvl_b,
   output wire logic o_pin_a,
   output wire logic o_pin_b
);
   timeunit 1ns;
   timeprecision 100ps;
   // same skew on both pins so simultaneous edges stay simultaneous
   assign #(SKEW_NS) o_pin_a = i_lvl_a;
   assign #(SKEW_NS) o_pin_b = i_lvl_b;
endmodule

// File: bench/tb_timer16_capture_output_control.sv
// bench: drives the capture block, queues expected interrupts, checks outputs
// assumes tc_pkg, tc_edge_if, the design files and tc_pulse_src are compiled first
`define CHK(nm, ex, gt) cmp(nm, 32'(ex), 32'(gt))
module tb_timer16_capture_output_control;
   timeunit 1ns;
   timeprecision 100ps;
   import tc_pkg::*;
   localparam int W = 8;
   logic           i_ref_clk = 1'b0;
   logic           i_reset_n = 1'b0;
   logic           cnt_en    = 1'b0;
   logic [1:0]     mode      = MODE_STOP;
   logic [1:0]     sel_a     = EDGE_NONE;
   logic [1:0]     sel_b     = EDGE_NONE;
   logic           a_cap     = 1'b0;
   logic           a_rev     = 1'b0;
   logic           b_cap     = 1'b0;
   logic           wr_a      = 1'b0;
   logic           wr_b      = 1'b0;
   logic [W-1:0]   wr_data   = '0;
   logic           lvl_set   = 1'b0;
   logic           lvl_rst   = 1'b0;
   logic           out_en    = 1'b0;
   logic           b_inv     = 1'b0;
   logic           ovf_clr   = 1'b0;
   logic           lvl_a     = 1'b0;
   logic           lvl_b     = 1'b0;
   wire logic      pin_a;
   wire logic      pin_b;
   logic [W-1:0]   cnt;
   logic [W-1:0]   reg_a;
   logic [W-1:0]   reg_b;
   logic           irq_a;
   logic           irq_b;
   logic           tout;
   logic           ovf;
   int             err_total = 0;
   int             n_compared = 0;
   logic [2:0]     exp_q[$];
   logic [31:0]    rs = 32'h30;
   logic           p;

   always #12.5 i_ref_clk = ~i_ref_clk;

   tc_pulse_src src (.i_lvl_a(lvl_a), .i_lvl_b(lvl_b), .o_pin_a(pin_a), .o_pin_b(pin_b));

   tc_capture_top #(.WIDTH(W)) dut (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_count_en(cnt_en), .i_mode(mode),
      .i_capture_in_a(pin_a), .i_capture_in_b(pin_b), .i_edge_sel_a(sel_a), .i_edge_sel_b(sel_b),
      .i_reg_a_capture(a_cap), .i_reg_a_rev_trig(a_rev), .i_reg_b_capture(b_cap),
      .i_wr_reg_a(wr_a), .i_wr_reg_b(wr_b), .i_wr_data(wr_data),
      .i_output_level_set(lvl_set), .i_output_level_reset(lvl_rst), .i_output_enable(out_en),
      .i_match_b_invert_enable(b_inv), .i_overflow_clear(ovf_clr),
      .o_timer_counter_value(cnt), .o_capture_compare_reg_a(reg_a), .o_capture_compare_reg_b(reg_b),
      .o_match_capture_irq_a(irq_a), .o_match_capture_irq_b(irq_b),
      .o_timer_output_pin(tout), .o_overflow_flag(ovf));

   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task automatic tk(input int n);
      repeat (n) @(posedge i_ref_clk);
      #2;
   endtask

   task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] gt);
      n_compared++;
      if (gt !== ex) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, gt);
      end
   endtask

   task automatic end_of_test();
      $display("counts: %0d compared, %0d mismatched", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // waits for every queued interrupt, bounded
   task automatic drain();
      int i;
      for (i = 0; i < 400 && exp_q.size() != 0; i++)
         tk(1);
      if (exp_q.size() != 0) begin
         err_total++;
         $display("[FAIL] pending irq expected 0 seen %0d", exp_q.size());
         end_of_test();
      end
      tk(8);
   endtask

   task automatic wreg(input logic to_a, input logic [W-1:0] v);
      wr_data = v;
      wr_a = to_a;
      wr_b = ~to_a;
      tk(1);
      wr_a = 1'b0;
      wr_b = 1'b0;
      tk(1);
   endtask

   task automatic stop();
      mode = MODE_STOP;
      tk(3);
   endtask

   // monitor: every cycle with an interrupt takes the oldest note; A and B together take one
   always @(negedge i_ref_clk) begin
      logic [2:0] e;
      if (i_reset_n === 1'b1 && (irq_a === 1'b1 || irq_b === 1'b1)) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 3'h0;
         `CHK("irq and pin", e, {irq_a, irq_b, tout});
      end
   end

   initial begin
      static logic [1:0] codes [5] = '{LVL_HIGH, LVL_KEEP, LVL_LOW, LVL_KEEP, LVL_HIGH};
      static logic       pins  [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      logic [W-1:0] k;
      logic [W-1:0] j;
      int           c;
      int           w;
      int           l;
      tk(8);
      i_reset_n = 1'b1;
      tk(3);
      `CHK("pin after reset", OUT_RST, tout);
      // level codes while stopped, ticks ignored
      for (int i = 0; i < 5; i++) begin
         {lvl_set, lvl_rst} = codes[i];
         cnt_en = 1'(rnd());
         tk(2);
         `CHK("level pin", pins[i], tout);
         `CHK("stopped counter", 0, cnt);
      end
      {lvl_set, lvl_rst} = LVL_KEEP;
      p = 1'b1;
      $display("test level done");
      // compare matches invert the output from the preset level
      out_en = 1'b1;
      cnt_en = 1'b1;
      for (int inv = 1; inv >= 0; inv--) begin
         b_inv = inv[0];
         k = W'(rnd() % 100 + 60);
         j = W'(rnd() % 40 + 10);
         wreg(1'b1, k);
         wreg(1'b0, j);
         exp_q.push_back({2'b01, p ^ inv[0]});
         p = p ^ inv[0];
         exp_q.push_back({2'b10, ~p});
         p = ~p;
         mode = MODE_FREE;
         drain();
         stop();
      end
      // duty change of register b while running
      b_inv = 1'b1;
      k = W'(rnd() % 40 + 60);
      j = W'(rnd() % 40 + 10);
      wreg(1'b1, k);
      wreg(1'b0, j);
      exp_q.push_back({2'b01, ~p});
      exp_q.push_back({2'b10, p});
      exp_q.push_back({2'b01, ~p});
      exp_q.push_back({2'b10, p});
      mode = MODE_FREE;
      for (c = 0; c < 300 && irq_b !== 1'b1; c++)
         tk(1);
      b_inv = 1'b0;
      tk(1);
      wreg(1'b0, j - 8'h5);
      b_inv = 1'b1;
      drain();
      // counter wrapped once here; clear so the later overflow check means something
      ovf_clr = 1'b1;
      stop();
      ovf_clr = 1'b0;
      $display("test compare done");
      // match-clear mode repeats every k+1 ticks
      b_cap = 1'b1;
      k = W'(rnd() % 30 + 5);
      wreg(1'b1, k);
      exp_q.push_back({2'b10, ~p});
      exp_q.push_back({2'b10, p});
      mode = MODE_CLR_MATCH;
      for (c = 0; c < 300 && irq_a !== 1'b1; c++)
         @(negedge i_ref_clk);
      c = 0;
      do begin
         @(negedge i_ref_clk);
         c++;
      end while (irq_a !== 1'b1 && c < 300);
      `CHK("match period", k + 1, c);
      tk(1);
      stop();
      drain();
      $display("test period done");
      // free-run capture with each edge select, glitch rejected
      out_en = 1'b0;
      b_inv = 1'b0;
      a_cap = 1'b1;
      a_rev = 1'b1;
      for (int s = 0; s < 4; s++) begin
         sel_a = s[1:0];
         mode = MODE_FREE;
         tk(4);
         lvl_a = 1'b1;
         tk(1);
         lvl_a = 1'b0;
         tk(6);
         w = rnd() % 20 + 4;
         if (sel_a == EDGE_RISE || sel_a == EDGE_BOTH)
            exp_q.push_back({2'b01, p});
         if (sel_a == EDGE_FALL || sel_a == EDGE_BOTH)
            exp_q.push_back({2'b01, p});
         lvl_a = 1'b1;
         tk(w);
         lvl_a = 1'b0;
         tk(10);
         drain();
         if (sel_a == EDGE_RISE)
            `CHK("high width", w, W'(reg_a - reg_b));
         stop();
      end
      $display("test edge done");
      // edge-clear mode: valid edge captures into b and clears
      sel_a = EDGE_RISE;
      mode = MODE_CLR_EDGE;
      w = rnd() % 20 + 4;
      l = rnd() % 20 + 4;
      exp_q.push_back({2'b01, p});
      exp_q.push_back({2'b01, p});
      lvl_a = 1'b1;
      tk(w);
      lvl_a = 1'b0;
      tk(l);
      lvl_a = 1'b1;
      tk(10);
      drain();
      `CHK("low width", l, W'(reg_b - reg_a));
      `CHK("counter cleared", 1'b1, cnt < 8'h20);
      // final fall only after the check, else it overwrites register a
      lvl_a = 1'b0;
      stop();
      // input b edge triggers register a with register b
      a_rev = 1'b0;
      sel_b = EDGE_RISE;
      mode = MODE_FREE;
      tk(4);
      exp_q.push_back({2'b11, p});
      lvl_a = 1'b1;
      lvl_b = 1'b1;
      tk(8);
      lvl_a = 1'b0;
      lvl_b = 1'b0;
      drain();
      `CHK("same trigger", reg_b, reg_a);
      // overflow after a full wrap, then cleared
      tk(260);
      `CHK("overflow set", 1'b1, ovf);
      ovf_clr = 1'b1;
      tk(1);
      ovf_clr = 1'b0;
      tk(1);
      `CHK("overflow clear", 1'b0, ovf);
      stop();
      $display("test capture done");
      end_of_test();
   end
endmodule
